//--- design/hub_port_phy_tuning_pkg.sv
// Constants for the hub port PHY tuning register bank.
// Assumes an AHB-Lite slave with 32-bit data, one register per word.
package hub_port_phy_tuning_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [16:0] IDX_UP_LINK = 17'h061c0;
  localparam logic [16:0] IDX_P2_LINK = 17'h069c0;
  localparam logic [16:0] IDX_P3_BOOST = 17'h06cca;
  localparam logic [16:0] IDX_P3_SQ = 17'h06ccc;
  localparam logic [16:0] IDX_P3_LINK = 17'h06dc0;
  localparam logic [16:0] IDX_P4_BOOST = 17'h070ca;
  localparam logic [16:0] IDX_P4_SQ = 17'h070cc;
  localparam logic [16:0] IDX_P4_LINK = 17'h071c0;

  // One-hot select positions produced by the address decoder.
  localparam int SEL_UP = 0;
  localparam int SEL_P2 = 1;
  localparam int SEL_P3L = 2;
  localparam int SEL_P4L = 3;
  localparam int SEL_P3B = 4;
  localparam int SEL_P4B = 5;
  localparam int SEL_P3Q = 6;
  localparam int SEL_P4Q = 7;

  // Field positions of the status byte.
  localparam int STATE_LSB = 4;
  localparam int RSVD_BIT = 3;

  // Values after reset.
  localparam logic [7:0] BOOST_RST = 8'h00;
  localparam logic [2:0] SQ_RST = 3'h0;

  // Drive current codes and their trims in percent.
  localparam logic [2:0] DRV_NOM = 3'h0;
  localparam logic [2:0] DRV_DN5 = 3'h1;
  localparam logic [2:0] DRV_UP10 = 3'h2;
  localparam logic [2:0] DRV_UP20 = 3'h4;
  localparam logic [2:0] DRV_UP30 = 3'h6;
  localparam logic [2:0] DRV_UP25 = 3'h7;
  localparam logic signed [5:0] PCT_NOM = 6'sh00;
  localparam logic signed [5:0] PCT_DN5 = -6'sh05;
  localparam logic signed [5:0] PCT_UP10 = 6'sh0a;
  localparam logic signed [5:0] PCT_UP20 = 6'sh14;
  localparam logic signed [5:0] PCT_UP30 = 6'sh1e;
  localparam logic signed [5:0] PCT_UP25 = 6'sh19;

  // Squelch codes and trip offsets in 12.5 mV steps.
  localparam logic [2:0] SQ_NOM = 3'h0;
  localparam logic [2:0] SQ_DN1 = 3'h1;
  localparam logic [2:0] SQ_DN2 = 3'h2;
  localparam logic [2:0] SQ_DN4 = 3'h4;
  localparam logic signed [3:0] STEP_NOM = 4'sh0;
  localparam logic signed [3:0] STEP_DN1 = -4'sh1;
  localparam logic signed [3:0] STEP_DN2 = -4'sh2;
  localparam logic signed [3:0] STEP_DN4 = -4'sh4;

  // Bus phase of the slave.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_WRITE = 2'b10
  } bus_phase_t;

endpackage

//--- design/hub_port_phy_tuning_regs.sv
// Per-port link status and HS PHY tuning registers behind AHB-Lite.
// Assumes a single AHB-Lite master, word transfers, link state inputs
// synchronous to hclk.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
module hub_port_phy_tuning_regs (
  input wire logic hclk, // Bus clock.
  input wire logic hresetn, // Async reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  output logic [31:0] hrdata, // Read data.
  input wire logic [3:0] up_link_state, // Upstream link state.
  input wire logic [2:0] up_link_sub_state, // Upstream sub-state.
  input wire logic [3:0] p2_link_state, // Port 2 link state.
  input wire logic [2:0] p2_link_sub_state, // Port 2 sub-state.
  input wire logic [3:0] p3_link_state, // Port 3 link state.
  input wire logic [2:0] p3_link_sub_state, // Port 3 sub-state.
  input wire logic [3:0] p4_link_state, // Port 4 link state.
  input wire logic [2:0] p4_link_sub_state, // Port 4 sub-state.
  output logic [2:0] port3_hs_drive_current_code, // To PHY.
  output logic [2:0] port4_hs_drive_current_code, // To PHY.
  output logic [2:0] port3_squelch_trip_code, // To PHY.
  output logic [2:0] port4_squelch_trip_code, // To PHY.
  output logic signed [5:0] port3_drive_pct, // Current trim.
  output logic signed [5:0] port4_drive_pct, // Current trim.
  output logic signed [3:0] port3_squelch_steps, // Trip offset.
  output logic signed [3:0] port4_squelch_steps // Trip offset.
);
  import hub_port_phy_tuning_pkg::*;

  // Decodes a byte address into a one-hot register select.
  function automatic logic [7:0] sel_of(input logic [31:0] a);
    logic [16:0] idx;
    logic hit;
    idx = a[18:2];
    hit = (a[31:19] == 13'h0000) && (a[1:0] == 2'b00);
    sel_of = 8'h00;
    if (hit) begin
      sel_of[SEL_UP] = (idx == IDX_UP_LINK);
      sel_of[SEL_P2] = (idx == IDX_P2_LINK);
      sel_of[SEL_P3L] = (idx == IDX_P3_LINK);
      sel_of[SEL_P4L] = (idx == IDX_P4_LINK);
      sel_of[SEL_P3B] = (idx == IDX_P3_BOOST);
      sel_of[SEL_P4B] = (idx == IDX_P4_BOOST);
      sel_of[SEL_P3Q] = (idx == IDX_P3_SQ);
      sel_of[SEL_P4Q] = (idx == IDX_P4_SQ);
    end
  endfunction

  // Maps a drive code to its trim; undefined codes, and codes 6 and 7 on port 3, stay nominal.
  function automatic logic signed [5:0] drive_pct(
    input logic [2:0] c,
    input logic p4
  );
    case (c)
      DRV_NOM: drive_pct = PCT_NOM;
      DRV_DN5: drive_pct = PCT_DN5;
      DRV_UP10: drive_pct = PCT_UP10;
      DRV_UP20: drive_pct = PCT_UP20;
      DRV_UP30: drive_pct = p4 ? PCT_UP30 : PCT_NOM;
      DRV_UP25: drive_pct = p4 ? PCT_UP25 : PCT_NOM;
      default: drive_pct = PCT_NOM;
    endcase
  endfunction

  // Maps a squelch code to its offset; undefined codes stay nominal.
  function automatic logic signed [3:0] sq_steps(input logic [2:0] c);
    case (c)
      SQ_NOM: sq_steps = STEP_NOM;
      SQ_DN1: sq_steps = STEP_DN1;
      SQ_DN2: sq_steps = STEP_DN2;
      SQ_DN4: sq_steps = STEP_DN4;
      default: sq_steps = STEP_NOM;
    endcase
  endfunction

  // Builds a status byte from live link state.
  function automatic logic [7:0] status_byte(
    input logic [3:0] st,
    input logic [2:0] sub
  );
    status_byte = {st, 1'b0, sub};
  endfunction

  bus_phase_t phase_q;
  bus_phase_t phase_d;
  logic [7:0] wsel_q;
  logic [7:0] wsel_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic addr_ok;
  logic [7:0] asel;
  logic [1:0][7:0] boost_n;
  logic [1:0][2:0] sq_n;
  logic [1:0][5:0] pct_n;
  logic [1:0][3:0] step_n;

  // An address phase is taken when selected, ready and NONSEQ or SEQ.
  assign addr_ok = hsel && hready && htrans[1];
  assign asel = sel_of(haddr);

  // Zero-wait slave that always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, rdata_q};

  // Phase tracking and write select capture.
  always_comb begin
    phase_d = PH_IDLE;
    wsel_d = 8'h00;
    case (phase_q)
      PH_IDLE, PH_WRITE: begin
        if (addr_ok && hwrite) begin
          phase_d = PH_WRITE;
          wsel_d = asel;
        end
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= PH_IDLE;
      wsel_q <= 8'h00;
    end else begin
      phase_q <= phase_d;
      wsel_q <= wsel_d;
    end
  end

  // Per-port tuning storage for ports 3 (index 0) and 4 (index 1).
  for (genvar i = 0; i < 2; i++) begin : g_port
    logic [7:0] boost_q;
    logic [7:0] boost_d;
    logic [2:0] sq_q;
    logic [2:0] sq_d;
    logic signed [5:0] pct_q;
    logic signed [5:0] pct_d;
    logic signed [3:0] step_q;
    logic signed [3:0] step_d;

    // Data-phase writes land here; each port has its own select.
    always_comb begin
      boost_d = boost_q;
      sq_d = sq_q;
      if (phase_q == PH_WRITE && wsel_q[SEL_P3B + i]) begin
        boost_d = hwdata[7:0];
      end
      if (phase_q == PH_WRITE && wsel_q[SEL_P3Q + i]) begin
        sq_d = hwdata[2:0];
      end
      pct_d = drive_pct(boost_d[2:0], i == 1);
      step_d = sq_steps(sq_d);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        boost_q <= BOOST_RST;
        sq_q <= SQ_RST;
        pct_q <= PCT_NOM;
        step_q <= STEP_NOM;
      end else begin
        boost_q <= boost_d;
        sq_q <= sq_d;
        pct_q <= pct_d;
        step_q <= step_d;
      end
    end

    assign boost_n[i] = boost_d;
    assign sq_n[i] = sq_d;
    assign pct_n[i] = pct_q;
    assign step_n[i] = step_q;
  end

  // Codes driven to the analog PHY.
  assign port3_hs_drive_current_code = g_port[0].boost_q[2:0];
  assign port4_hs_drive_current_code = g_port[1].boost_q[2:0];
  assign port3_squelch_trip_code = g_port[0].sq_q;
  assign port4_squelch_trip_code = g_port[1].sq_q;
  assign port3_drive_pct = pct_n[0];
  assign port4_drive_pct = pct_n[1];
  assign port3_squelch_steps = step_n[0];
  assign port4_squelch_steps = step_n[1];

  // Read mux sampled at the address phase; tuning bytes use the next
  // value so a read right after a write sees the new data.
  always_comb begin
    rdata_d = 8'h00;
    if (addr_ok && !hwrite) begin
      case (1'b1)
        asel[SEL_UP]: rdata_d = status_byte(up_link_state,
          up_link_sub_state);
        asel[SEL_P2]: rdata_d = status_byte(p2_link_state,
          p2_link_sub_state);
        asel[SEL_P3L]: rdata_d = status_byte(p3_link_state,
          p3_link_sub_state);
        asel[SEL_P4L]: rdata_d = status_byte(p4_link_state,
          p4_link_sub_state);
        asel[SEL_P3B]: rdata_d = boost_n[0];
        asel[SEL_P4B]: rdata_d = boost_n[1];
        asel[SEL_P3Q]: rdata_d = {5'h00, sq_n[0]};
        asel[SEL_P4Q]: rdata_d = {5'h00, sq_n[1]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  localparam logic [31:0] A_UP = {13'h0000, IDX_UP_LINK, 2'b00};
  localparam logic [31:0] A_P2 = {13'h0000, IDX_P2_LINK, 2'b00};
  localparam logic [31:0] A_P3B = {13'h0000, IDX_P3_BOOST, 2'b00};
  localparam logic [31:0] A_P4B = {13'h0000, IDX_P4_BOOST, 2'b00};
  localparam logic [31:0] A_P3Q = {13'h0000, IDX_P3_SQ, 2'b00};
  localparam logic [31:0] A_P4Q = {13'h0000, IDX_P4_SQ, 2'b00};

  // Port 2 status reads give live state with bit 3 clear.
  a_p2_status_read: assert property (
    addr_ok && !hwrite && haddr == A_P2 |=>
      hrdata[7:4] == $past(p2_link_state) && !hrdata[RSVD_BIT]
      && hrdata[2:0] == $past(p2_link_sub_state)
      && hrdata[31:8] == 24'h000000)
    else $error("Port 2 status read wrong.");

  // Upstream status uses the same layout.
  a_up_status_read: assert property (
    addr_ok && !hwrite && haddr == A_UP |=>
      hrdata[7:0] == {$past(up_link_state), 1'b0,
        $past(up_link_sub_state)})
    else $error("Upstream status read wrong.");

  // A written port 4 boost byte reads back whole in the next transfer.
  a_boost_readback: assert property (
    addr_ok && hwrite && haddr == A_P4B ##2
      (addr_ok && !hwrite && haddr == A_P4B) |=>
      hrdata[7:0] == $past(hwdata[7:0], 2))
    else $error("Boost byte readback wrong.");

  // Code two raises port 3 current by ten percent.
  a_boost_up10: assert property (
    addr_ok && hwrite && haddr == A_P3B ##1 hwdata[2:0] == DRV_UP10
      |=> port3_hs_drive_current_code == DRV_UP10
      && port3_drive_pct == PCT_UP10)
    else $error("Port 3 drive trim wrong.");

  // Code six raises port 4 current by thirty percent.
  a_p4_boost30: assert property (
    addr_ok && hwrite && haddr == A_P4B ##1 hwdata[2:0] == DRV_UP30
      |=> port4_drive_pct == PCT_UP30)
    else $error("Port 4 thirty percent trim wrong.");

  // A port 4 boost write leaves the whole port 3 byte untouched.
  a_boost_indep: assert property (
    addr_ok && hwrite && haddr == A_P4B |=> ##1
      $stable(g_port[0].boost_q))
    else $error("Port 3 boost disturbed.");

  // Squelch reserved bits read zero.
  a_sq_rsvd_zero: assert property (
    addr_ok && !hwrite && haddr == A_P3Q |=> hrdata[7:3] == 5'h00)
    else $error("Squelch reserved bits not zero.");

  // Code four lowers the port 4 trip point by four steps.
  a_sq_dn50: assert property (
    addr_ok && hwrite && haddr == A_P4Q ##1 hwdata[2:0] == SQ_DN4
      |=> port4_squelch_steps == STEP_DN4
      && port4_squelch_trip_code == SQ_DN4)
    else $error("Port 4 squelch trip wrong.");

  // A port 3 squelch write leaves port 4 untouched.
  a_sq_indep: assert property (
    addr_ok && hwrite && haddr == A_P3Q |=> ##1
      $stable(port4_squelch_trip_code))
    else $error("Port 4 squelch disturbed.");

  // Writes to a status address change no tuning code.
  a_ro_ignored: assert property (
    addr_ok && hwrite && haddr == A_P2 |=> ##1
      $stable({port3_hs_drive_current_code, port4_hs_drive_current_code,
        port3_squelch_trip_code, port4_squelch_trip_code}))
    else $error("Status write changed a code.");

endmodule // hub_port_phy_tuning_regs

//--- tb/testbench.sv
// Self-checking bench for the hub port PHY tuning register bank.
// Assumes a zero-wait AHB-Lite slave whose hreadyout is looped back to hready.
`timescale 1ns/1ps
module testbench;
  import hub_port_phy_tuning_pkg::*;

  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rdy_cap;
  logic [31:0] haddr, hwdata, hrdata, rd_cap;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [27:0] lnk;
  logic [3:0] up_st, p2_st, p3_st, p4_st;
  logic [2:0] up_sub, p2_sub, p3_sub, p4_sub, p3_drv, p4_drv, p3_sq, p4_sq;
  logic signed [5:0] p3_pct, p4_pct;
  logic signed [3:0] p3_stp, p4_stp;
  int errors, tests_run;
  int cycles = 0;
  logic signed [5:0] p3_tab [8] = '{6'sh00, -6'sh05, 6'sh0a, 6'sh00,
    6'sh14, 6'sh00, 6'sh00, 6'sh00};
  logic signed [5:0] p4_tab [8] = '{6'sh00, -6'sh05, 6'sh0a, 6'sh00,
    6'sh14, 6'sh00, 6'sh1e, 6'sh19};
  logic signed [3:0] stp_tab [8] = '{4'sh0, -4'sh1, -4'sh2, 4'sh0, -4'sh4, 4'sh0, 4'sh0, 4'sh0};
  logic [27:0] pat [2] = '{28'h9a5c3f1, 28'h65a3c0e};

  // The single slave's ready is the bus ready; link inputs come from one vector.
  assign hready = hreadyout;
  assign {up_st, up_sub, p2_st, p2_sub, p3_st, p3_sub, p4_st, p4_sub} = lnk;

  hub_port_phy_tuning_regs hub_port_phy_tuning_regs_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .up_link_state(up_st), .up_link_sub_state(up_sub),
    .p2_link_state(p2_st), .p2_link_sub_state(p2_sub),
    .p3_link_state(p3_st), .p3_link_sub_state(p3_sub),
    .p4_link_state(p4_st), .p4_link_sub_state(p4_sub),
    .port3_hs_drive_current_code(p3_drv), .port4_hs_drive_current_code(p4_drv),
    .port3_squelch_trip_code(p3_sq), .port4_squelch_trip_code(p4_sq),
    .port3_drive_pct(p3_pct), .port4_drive_pct(p4_pct),
    .port3_squelch_steps(p3_stp), .port4_squelch_steps(p4_stp)
  );

  // Free-running bus clock at 125 MHz.
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Bus answers are captured at the edge so reads never race the slave.
  always @(posedge hclk) begin
    rd_cap <= hrdata;
    rdy_cap <= hready;
  end

  // Cuts a hung run short and reports it as a mismatch.
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end

  function automatic logic [31:0] ba(input logic [16:0] i);
    return {13'h0, i, 2'b00};
  endfunction

  function automatic logic [31:0] stat(input logic [3:0] s, input logic [2:0] u);
    return {24'h0, s, 1'b0, u};
  endfunction

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t output %h expected %h", $time, got, exp);
    end
  endtask

  // One single-word transfer: address phase, then data phase, each held until ready.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do begin @(posedge hclk); #1; end while (rdy_cap !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); #1; end while (rdy_cap !== 1'b1);
    rd = rd_cap;
  endtask

  task automatic wr(input logic [16:0] i, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, ba(i), v, d);
  endtask

  task automatic rd_chk(input logic [16:0] i, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, ba(i), 32'h0, d);
    chk_reg(d, exp);
  endtask

  // Main sequence: reset, status bytes, boost codes, squelch codes, refusals, reset again.
  initial begin
    logic [2:0] cd;
    logic [31:0] d;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hresetn = 1'b0;
    lnk = 28'h0;
    errors = 0;
    tests_run = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    rd_chk(IDX_P3_BOOST, 32'h0);
    rd_chk(IDX_P4_SQ, 32'h0);
    chk_out({2'b00, p3_drv, p4_drv}, 8'h00);
    // Status bytes track the live link inputs and ignore writes.
    foreach (pat[k]) begin
      lnk <= pat[k];
      wr(IDX_P2_LINK, 32'hffffffff);
      wr(IDX_P4_LINK, 32'h00000088);
      chk_out({2'b00, p3_drv, p4_sq}, 8'h00);
      rd_chk(IDX_UP_LINK, stat(lnk[27:24], lnk[23:21]));
      rd_chk(IDX_P2_LINK, stat(lnk[20:17], lnk[16:14]));
      rd_chk(IDX_P3_LINK, stat(lnk[13:10], lnk[9:7]));
      rd_chk(IDX_P4_LINK, stat(lnk[6:3], lnk[2:0]));
    end
    // Every drive code on both ports, upper bits stored as written.
    for (int c = 0; c < 8; c++) begin
      cd = 3'(c);
      wr(IDX_P3_BOOST, {24'hffffff, cd, 2'b10, cd});
      wr(IDX_P4_BOOST, {24'h0, ~cd, 2'b01, cd});
      chk_out({2'b00, p3_drv, p4_drv}, {2'b00, cd, cd});
      chk_out(8'(p3_pct), 8'(p3_tab[c]));
      chk_out(8'(p4_pct), 8'(p4_tab[c]));
      rd_chk(IDX_P4_BOOST, {24'h0, ~cd, 2'b01, cd});
      rd_chk(IDX_P3_BOOST, {24'h0, cd, 2'b10, cd});
    end
    // Every squelch code, ports written with opposite codes.
    for (int c = 0; c < 8; c++) begin
      cd = 3'(c);
      wr(IDX_P3_SQ, {24'hffffff, 5'h1f, cd});
      wr(IDX_P4_SQ, {29'h0, ~cd});
      chk_out({2'b00, p3_sq, p4_sq}, {2'b00, cd, ~cd});
      chk_out(8'(p3_stp), 8'(stp_tab[c]));
      chk_out(8'(p4_stp), 8'(stp_tab[7 - c]));
      rd_chk(IDX_P3_SQ, {29'h0, cd});
      rd_chk(IDX_P4_SQ, {29'h0, ~cd});
    end
    // Misaligned write is dropped; unmapped read gives zero with an OKAY response.
    bus(1'b1, ba(IDX_P3_BOOST) | 32'h2, 32'h55, d);
    rd_chk(IDX_P3_BOOST, {24'h0, 3'h7, 2'b10, 3'h7});
    rd_chk(17'h06cc9, 32'h0);
    chk_out({7'h0, hresp}, 8'h00);
    // A transfer with the slave not selected is ignored.
    hsel <= 1'b0;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr <= ba(IDX_P4_SQ);
    @(posedge hclk);
    #1;
    htrans <= 2'b00;
    hwdata <= 32'h7;
    @(posedge hclk);
    #1;
    rd_chk(IDX_P4_SQ, 32'h0);
    // A second reset in mid-run returns the codes and bytes to zero.
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    chk_out({2'b00, p3_sq, p4_drv}, 8'h00);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    rd_chk(IDX_P4_BOOST, 32'h0);
    end_sim();
  end
endmodule // testbench
